/* File: hdl/macacc_datapath.sv */
// Multiply and add/subtract datapath with one registered stage.
// Assumes start is a one-cycle pulse in the core clock domain.

`timescale 1ns/100ps

module macacc_datapath
  import macacc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              start_i,
  input  wire macacc_job_type    job_i,
  output logic                   done_o,
  output macacc_result_type      result_o
);

  logic signed [WORD_W:0]   opa_ext;
  logic signed [WORD_W:0]   opb_ext;
  logic signed [PROD_W+1:0] prod_full;
  logic        [ACC_W-1:0]  prod_acc;
  logic        [ACC_W-1:0]  acc_next;

  // ****************************************
  // Operand extension and product
  // ****************************************
  always_comb begin
    if (job_i.ctrl.sign_select_bit) begin
      opa_ext = {job_i.operand_a[WORD_W-1], job_i.operand_a};
      opb_ext = {job_i.operand_b[WORD_W-1], job_i.operand_b};
    end else begin
      opa_ext = {1'b0, job_i.operand_a};
      opb_ext = {1'b0, job_i.operand_b};
    end
    prod_full = (PROD_W+2)'(opa_ext * opb_ext);
    // Top bit carries the sign of the product when signed
    if (job_i.ctrl.sign_select_bit) begin
      prod_acc = {{(ACC_W-PROD_W){prod_full[PROD_W-1]}}, prod_full[PROD_W-1:0]};
    end else begin
      prod_acc = {{(ACC_W-PROD_W){1'b0}}, prod_full[PROD_W-1:0]};
    end
  end

  // ****************************************
  // Operation select
  // ****************************************
  always_comb begin
    case (job_i.ctrl.operation_select_bit)
      OP_MUL:  acc_next = prod_acc;
      OP_MAC:  acc_next = job_i.acc + prod_acc;
      OP_MNEG: acc_next = ACC_W'(0) - prod_acc;
      OP_MSUB: acc_next = job_i.acc - prod_acc;
      default: acc_next = prod_acc;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_o <= '{ACC_RESET, ACC_RESET[PROD_W-1:0]};
    end else if (start_i) begin
      result_o <= '{acc_next, prod_full[PROD_W-1:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= start_i;
    end
  end

endmodule : macacc_datapath

/* File: hdl/macacc_pkg.sv */
// Package for the multiply/accumulate accumulator block: register map,
// control field layout, operation codes and reset values.
// Assumes an APB master with 32-bit data and word-aligned byte addresses.

package macacc_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam int unsigned APB_ADDR_W     = 8;
  localparam int unsigned IDX_CTRL       = 0;
  localparam int unsigned IDX_OPERAND_A  = 1;
  localparam int unsigned IDX_OPERAND_B  = 2;
  localparam int unsigned IDX_ACC_HIGH   = 3;
  localparam int unsigned IDX_ACC_MID    = 4;
  localparam int unsigned IDX_ACC_LOW    = 5;
  localparam int unsigned IDX_RB_MID     = 8;

  localparam logic [APB_ADDR_W-1:0] ADDR_CTRL      = APB_ADDR_W'(IDX_CTRL * 4);
  localparam logic [APB_ADDR_W-1:0] ADDR_OPERAND_A = APB_ADDR_W'(IDX_OPERAND_A * 4);
  localparam logic [APB_ADDR_W-1:0] ADDR_OPERAND_B = APB_ADDR_W'(IDX_OPERAND_B * 4);
  localparam logic [APB_ADDR_W-1:0] ADDR_ACC_HIGH  = APB_ADDR_W'(IDX_ACC_HIGH * 4);
  localparam logic [APB_ADDR_W-1:0] ADDR_ACC_MID   = APB_ADDR_W'(IDX_ACC_MID * 4);
  localparam logic [APB_ADDR_W-1:0] ADDR_ACC_LOW   = APB_ADDR_W'(IDX_ACC_LOW * 4);
  localparam logic [APB_ADDR_W-1:0] ADDR_RB_MID    = APB_ADDR_W'(IDX_RB_MID * 4);

  // ****************************************
  // Widths, field positions, reset values
  // ****************************************
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned ACC_W    = 48;
  localparam int unsigned PROD_W   = 32;
  localparam int unsigned HIGH_LSB = 32;
  localparam int unsigned MID_LSB  = 16;
  localparam int unsigned LOW_LSB  = 0;
  localparam int unsigned CTRL_W   = 4;

  localparam int unsigned CTRL_SIGN_POS = 0;
  localparam int unsigned CTRL_OP_LSB   = 1;
  localparam int unsigned CTRL_RBC_POS  = 3;

  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [ACC_W-1:0]  ACC_RESET  = 48'h0000_0000_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OP_MUL,
    OP_MAC,
    OP_MNEG,
    OP_MSUB
  } macacc_op_type;

  typedef struct packed {
    logic          readback_control_bit;
    macacc_op_type operation_select_bit;
    logic          sign_select_bit;
  } macacc_ctrl_type;

  localparam macacc_ctrl_type CTRL_RESET = '{1'b0, OP_MUL, 1'b0};

  typedef struct packed {
    logic [WORD_W-1:0] operand_a;
    logic [WORD_W-1:0] operand_b;
    logic [ACC_W-1:0]  acc;
    macacc_ctrl_type   ctrl;
  } macacc_job_type;

  typedef struct packed {
    logic [ACC_W-1:0]  acc;
    logic [PROD_W-1:0] product;
  } macacc_result_type;

endpackage : macacc_pkg

/* File: hdl/macacc_top.sv */
// Accumulator and readback registers of a 16-bit multiply/accumulate unit,
// reached over an APB slave port with one wait state per transfer.
// Assumes a single core clock and a synchronous active-high reset.
//
// Function
// - Accumulator is 48 bits held as three 16-bit words: high, middle, low.
// - High accumulator word holds accumulator bits 47 down to 32.
// - In signed operations, accumulator bit 47 is the sign bit.
// - Middle accumulator word holds accumulator bits 31 down to 16.
// - Low accumulator word holds accumulator bits 15 down to 0.
// - All accumulator words and the readback word clear to zero on reset.
// - Readback word is read-only; shows result bits 31:16 when control or mul/neg.
// - With control 0 and accumulate/subtract, readback may differ from middle word.
// - Readback holds until an operation started by writing both operands finishes.
// - Writing both operands starts selected operation; result goes to accumulator.

`timescale 1ns/100ps

module macacc_top
  import macacc_pkg::*;
(
  input  wire logic                  CLK_I,
  input  wire logic                  SRST_I,
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [APB_ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]           PWDATA_I,
  output logic      [31:0]           PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [ACC_W-1:0]   acc_reg;
  logic [ACC_W-1:0]   acc_next;
  logic [WORD_W-1:0]  opa_reg;
  logic [WORD_W-1:0]  opb_reg;
  logic [WORD_W-1:0]  rb_mid_reg;
  logic [WORD_W-1:0]  rb_mid_next;
  macacc_ctrl_type    ctrl_reg;
  macacc_ctrl_type    last_ctrl_reg;
  logic               opa_loaded_reg;
  logic               opb_loaded_reg;
  logic               start_reg;
  logic               done;
  macacc_result_type  result;
  macacc_job_type     job;

  logic               access;
  logic               commit;
  logic               wr_commit;
  logic               rd_commit;
  logic               addr_ok;
  logic               addr_ro;
  logic [WORD_W-1:0]  rd_word;
  logic [WORD_W-1:0]  wr_word;
  logic               wr_ctrl;
  logic               wr_opa;
  logic               wr_opb;
  logic               wr_high;
  logic               wr_mid;
  logic               wr_low;
  logic               start_now;

  assign access    = PSEL_I & PENABLE_I;
  assign commit    = access & PREADY_O;
  assign wr_commit = commit & PWRITE_I & addr_ok & ~addr_ro;
  assign rd_commit = commit & ~PWRITE_I;
  assign wr_word   = PWDATA_I[WORD_W-1:0];

  // ****************************************
  // Register map, byte address = index * 4
  // ****************************************
  // 0x00 control: bit 0 signed, bits 2:1 operation, bit 3 readback control
  // 0x04 operand A
  // 0x08 operand B
  // 0x0C accumulator high word
  // 0x10 accumulator middle word
  // 0x14 accumulator low word
  // 0x20 middle readback word, read-only; writes answer with an error
  // Other addresses answer with an error, read as zero and ignore writes
  // Bits 31:16 of every read are zero; only data bits 15:0 are written

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    addr_ok = 1'b1;
    addr_ro = 1'b0;
    rd_word = WORD_RESET;
    if (PADDR_I == ADDR_CTRL) begin
      rd_word = {{(WORD_W-CTRL_W){1'b0}}, ctrl_reg};
    end else if (PADDR_I == ADDR_OPERAND_A) begin
      rd_word = opa_reg;
    end else if (PADDR_I == ADDR_OPERAND_B) begin
      rd_word = opb_reg;
    end else if (PADDR_I == ADDR_ACC_HIGH) begin
      rd_word = acc_reg[HIGH_LSB +: WORD_W];
    end else if (PADDR_I == ADDR_ACC_MID) begin
      rd_word = acc_reg[MID_LSB +: WORD_W];
    end else if (PADDR_I == ADDR_ACC_LOW) begin
      rd_word = acc_reg[LOW_LSB +: WORD_W];
    end else if (PADDR_I == ADDR_RB_MID) begin
      rd_word = rb_mid_reg;
      addr_ro = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign wr_ctrl = wr_commit & (PADDR_I == ADDR_CTRL);
  assign wr_opa  = wr_commit & (PADDR_I == ADDR_OPERAND_A);
  assign wr_opb  = wr_commit & (PADDR_I == ADDR_OPERAND_B);
  assign wr_high = wr_commit & (PADDR_I == ADDR_ACC_HIGH);
  assign wr_mid  = wr_commit & (PADDR_I == ADDR_ACC_MID);
  assign wr_low  = wr_commit & (PADDR_I == ADDR_ACC_LOW);

  // ****************************************
  // APB answer: one wait state, registered
  // ****************************************
  // Ready drops after each answer, so one access phase answers only once
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      PREADY_O <= 1'b0;
    end else begin
      PREADY_O <= access & ~PREADY_O;
    end
  end

  // Read data is taken in the wait cycle and dropped after the answer
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      PRDATA_O <= {{(32-WORD_W){1'b0}}, WORD_RESET};
    end else if (access & ~PREADY_O & ~PWRITE_I) begin
      PRDATA_O <= {{(32-WORD_W){1'b0}}, rd_word};
    end else if (rd_commit) begin
      PRDATA_O <= 32'h0000_0000;
    end
  end

  // Unmapped addresses and writes to the readback word answer with an error
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      PSLVERR_O <= 1'b0;
    end else if (access & ~PREADY_O) begin
      PSLVERR_O <= ~addr_ok | (PWRITE_I & addr_ro);
    end else begin
      PSLVERR_O <= 1'b0;
    end
  end

  // ****************************************
  // Control and operand registers
  // ****************************************
  // Only the low four data bits of the control word are kept
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= macacc_ctrl_type'(wr_word[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      opa_reg <= WORD_RESET;
    end else if (wr_opa) begin
      opa_reg <= wr_word;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      opb_reg <= WORD_RESET;
    end else if (wr_opb) begin
      opb_reg <= wr_word;
    end
  end

  // ****************************************
  // Start when both operands have been loaded
  // ****************************************
  assign start_now = (wr_opa | opa_loaded_reg) & (wr_opb | opb_loaded_reg)
                   & (wr_opa | wr_opb);

  // A flag marks an operand written since the last start; a rewrite only replaces it
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      opa_loaded_reg <= 1'b0;
    end else if (start_now) begin
      opa_loaded_reg <= 1'b0;
    end else if (wr_opa) begin
      opa_loaded_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      opb_loaded_reg <= 1'b0;
    end else if (start_now) begin
      opb_loaded_reg <= 1'b0;
    end else if (wr_opb) begin
      opb_loaded_reg <= 1'b1;
    end
  end

  // Start is registered so the datapath sees the operand just written
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= start_now;
    end
  end

  // Operation parameters are captured with the operation
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      last_ctrl_reg <= CTRL_RESET;
    end else if (start_reg) begin
      last_ctrl_reg <= ctrl_reg;
    end
  end

  // ****************************************
  // Datapath
  // ****************************************
  // Operands, accumulator and control are taken at the start edge
  assign job = '{opa_reg, opb_reg, acc_reg, ctrl_reg};

  macacc_datapath u_datapath (
    .clk_i    (CLK_I),
    .srst_i   (SRST_I),
    .start_i  (start_reg),
    .job_i    (job),
    .done_o   (done),
    .result_o (result)
  );

  // ****************************************
  // Accumulator
  // ****************************************
  // A finished operation wins over a software write in the same cycle
  always_comb begin
    acc_next = acc_reg;
    if (done) begin
      acc_next = result.acc;
    end else begin
      if (wr_high) begin
        acc_next[HIGH_LSB +: WORD_W] = wr_word;
      end
      if (wr_mid) begin
        acc_next[MID_LSB +: WORD_W] = wr_word;
      end
      if (wr_low) begin
        acc_next[LOW_LSB +: WORD_W] = wr_word;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      acc_reg <= ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // ****************************************
  // Middle readback word
  // ****************************************
  // Accumulating with control clear shows the raw product, not the sum
  // Writes to the accumulator or control registers leave it alone
  always_comb begin
    rb_mid_next = rb_mid_reg;
    if (done) begin
      if (last_ctrl_reg.readback_control_bit
          || last_ctrl_reg.operation_select_bit == OP_MUL
          || last_ctrl_reg.operation_select_bit == OP_MNEG) begin
        rb_mid_next = result.acc[MID_LSB +: WORD_W];
      end else begin
        rb_mid_next = result.product[MID_LSB +: WORD_W];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rb_mid_reg <= WORD_RESET;
    end else begin
      rb_mid_reg <= rb_mid_next;
    end
  end

endmodule : macacc_top

/* File: sim/macacc_assertions.sv */
// Checker for the accumulator register block, watching only its APB port.
// Assumes it is bound to macacc_top and that reset is synchronous, active high.
`timescale 1ns/100ps
module macacc_assertions
  import macacc_pkg::*;
(
  input wire logic                  CLK_I,
  input wire logic                  SRST_I,
  input wire logic                  PSEL_I,
  input wire logic                  PENABLE_I,
  input wire logic                  PWRITE_I,
  input wire logic [APB_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0]           PWDATA_I,
  input wire logic [31:0]           PRDATA_O,
  input wire logic                  PREADY_O,
  input wire logic                  PSLVERR_O
);
  logic [CTRL_W-1:0] ctrl_reg;
  logic              done;
  logic              mapped;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  assign done   = PSEL_I && PENABLE_I && PREADY_O;
  assign mapped = PADDR_I inside {ADDR_CTRL, ADDR_OPERAND_A, ADDR_OPERAND_B, ADDR_ACC_HIGH, ADDR_ACC_MID,
                                  ADDR_ACC_LOW, ADDR_RB_MID};
  // Shadow of the last control word written
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ctrl_reg <= '0;
    end else if (done && PWRITE_I && PADDR_I == ADDR_CTRL) begin
      ctrl_reg <= PWDATA_I[CTRL_W-1:0];
    end
  end
  a_reset_clear: assert property ($fell(SRST_I) |-> !PREADY_O && !PSLVERR_O && PRDATA_O == 32'h0)
    else $error("outputs not cleared by reset");
  a_ready_wait: assert property ($rose(PSEL_I && PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
    else $error("ready not after one wait cycle");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  a_idle_quiet: assert property (!(PSEL_I && PENABLE_I) |=> !PREADY_O && !PSLVERR_O)
    else $error("answer without access phase");
  a_rb_readonly: assert property (done && PWRITE_I && PADDR_I == ADDR_RB_MID |-> PSLVERR_O)
    else $error("readback write not refused");
  a_map_okay: assert property (done && mapped && !(PWRITE_I && PADDR_I == ADDR_RB_MID) |-> !PSLVERR_O)
    else $error("mapped access refused");
  a_unmapped_err: assert property (done && !mapped |-> PSLVERR_O && (PWRITE_I || PRDATA_O == 32'h0))
    else $error("unmapped access not refused");
  a_word_width: assert property (done && !PWRITE_I |-> PRDATA_O[31:16] == 16'h0)
    else $error("read data above bit 15");
  a_ctrl_keeps: assert property (done && !PWRITE_I && PADDR_I == ADDR_CTRL |-> PRDATA_O == 32'(ctrl_reg))
    else $error("control word not kept");
endmodule : macacc_assertions

bind macacc_top macacc_assertions i_chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O));

/* File: sim/test_macacc_top.sv */
// Self-checking bench for the accumulator register block with a behavioural model.
// Assumes the APB slave answers after one wait state and clears on SRST_I.
`timescale 1ns/100ps
module test_macacc_top
  import macacc_pkg::*;
;
  logic                  CLK_I;
  logic                  SRST_I;
  logic                  PSEL_I;
  logic                  PENABLE_I;
  logic                  PWRITE_I;
  logic [APB_ADDR_W-1:0] PADDR_I;
  logic [31:0]           PWDATA_I;
  logic [31:0]           PRDATA_O;
  logic                  PREADY_O;
  logic                  PSLVERR_O;
  int                    n_mismatch;
  int                    n_compared;
  int                    cycles;
  logic [31:0]           rd, x, y, prod;
  logic                  er;
  logic [47:0]           m_acc, ext;
  logic [15:0]           m_rb, a, b;
  logic [3:0]            ctrl;
  logic [7:0]            map [7] = '{ADDR_CTRL, ADDR_OPERAND_A, ADDR_OPERAND_B, ADDR_ACC_HIGH, ADDR_ACC_MID,
                                     ADDR_ACC_LOW, ADDR_RB_MID};

  macacc_top i_dut (.CLK_I(CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O));

  initial begin
    CLK_I = 1'b0;
    forever #2.5 CLK_I = ~CLK_I;
  end

  // ****
  // Bus tasks and checks
  // ****
  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    PSEL_I <= 1'b1;
    PWRITE_I <= wr;
    PADDR_I <= ad;
    PWDATA_I <= wd;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLK_I); while (PREADY_O !== 1'b1);
    rd = PRDATA_O;
    er = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge CLK_I);
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rchk(input string nm, input logic [7:0] ad, input logic [15:0] e, input logic xe);
    apb(1'b0, ad, 32'h0);
    chk(nm, {16'h0, e}, rd);
    chk({nm, " err"}, {31'h0, xe}, {31'h0, er});
  endtask : rchk

  task automatic reset_all;
    SRST_I <= 1'b1;
    repeat (8) @(posedge CLK_I);
    SRST_I <= 1'b0;
    @(posedge CLK_I);
    m_rb = 16'h0;
    for (int i = 0; i < 7; i++) rchk("reset", map[i], 16'h0, 1'b0);
  endtask : reset_all

  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end

  // ****
  // Main sequence
  // ****
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    SRST_I = 1'b1;
    PSEL_I = 1'b0;
    PENABLE_I = 1'b0;
    PWRITE_I = 1'b0;
    PADDR_I = 8'h0;
    PWDATA_I = 32'h0;
    void'($urandom(95));
    reset_all();
    apb(1'b1, ADDR_RB_MID, 32'h0000FFFF);
    chk("rb write err", 32'h1, {31'h0, er});
    rchk("unmapped", 8'h1C, 16'h0, 1'b1);
    for (int k = 0; k < 16; k++) begin
      ctrl = 4'(k);
      a = (k % 3 == 0) ? 16'h8000 : 16'($urandom);
      b = 16'($urandom);
      m_acc = {16'($urandom), 16'($urandom), 16'($urandom)};
      apb(1'b1, ADDR_ACC_HIGH, {16'($urandom), m_acc[47:32]});
      apb(1'b1, ADDR_ACC_MID, {16'h0, m_acc[31:16]});
      apb(1'b1, ADDR_ACC_LOW, {16'h0, m_acc[15:0]});
      rchk("preset mid", ADDR_ACC_MID, m_acc[31:16], 1'b0);
      apb(1'b1, ADDR_CTRL, {28'h0, ctrl});
      apb(1'b1, ADDR_OPERAND_A, {16'h0, ~a});
      apb(1'b1, ADDR_OPERAND_A, {16'h0, a});
      rchk("rb early", ADDR_RB_MID, m_rb, 1'b0);
      apb(1'b1, ADDR_OPERAND_B, {16'h0, b});
      x = ctrl[0] ? {{16{a[15]}}, a} : {16'h0, a};
      y = ctrl[0] ? {{16{b[15]}}, b} : {16'h0, b};
      prod = x * y;
      ext = ctrl[0] ? {{16{prod[31]}}, prod} : {16'h0, prod};
      case (macacc_op_type'(ctrl[2:1]))
        OP_MUL:  m_acc = ext;
        OP_MAC:  m_acc = m_acc + ext;
        OP_MNEG: m_acc = -ext;
        default: m_acc = m_acc - ext;
      endcase
      m_rb = (ctrl[3] || !ctrl[1]) ? m_acc[31:16] : prod[31:16];
      rchk("acc high", ADDR_ACC_HIGH, m_acc[47:32], 1'b0);
      rchk("acc mid", ADDR_ACC_MID, m_acc[31:16], 1'b0);
      rchk("acc low", ADDR_ACC_LOW, m_acc[15:0], 1'b0);
      rchk("readback", ADDR_RB_MID, m_rb, 1'b0);
      rchk("ctrl", ADDR_CTRL, {12'h0, ctrl}, 1'b0);
      rchk("operand b", ADDR_OPERAND_B, b, 1'b0);
      rchk("operand a", ADDR_OPERAND_A, a, 1'b0);
      apb(1'b1, ADDR_ACC_LOW, {16'h0, ~m_acc[15:0]});
      rchk("rb hold", ADDR_RB_MID, m_rb, 1'b0);
    end
    apb(1'b1, ADDR_OPERAND_B, 32'h00001234);
    rchk("no start", ADDR_ACC_HIGH, m_acc[47:32], 1'b0);
    reset_all();
    results();
  end
endmodule : test_macacc_top
